// [verification/pcr_config_caps_properties.sv]
module pcr_config_caps_props
(
    // watched ports
    input logic        clock_i,
    input logic        rstn_i,
    input logic        cfg_req_i,
    input logic        cfg_write_i,
    input logic [5:0]  cfg_dw_addr_i,
    input logic [3:0]  cfg_byte_en_i,
    input logic [31:0] cfg_wdata_i,
    input logic        cfg_ack_o,
    input logic [31:0] cfg_rdata_o,
    input logic        auxiliary_supply_i,
    input logic        cardbus_mode_i
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clock_i); endclocking
    default disable iff (!rstn_i);
    wire tk = cfg_req_i && !cfg_ack_o;
    wire rd = tk && !cfg_write_i;
    wire rpm = rd && cfg_dw_addr_i == 6'h37;
    ////////////////////////////////////////////////////////////////////////
    property p_ack; tk |=> cfg_ack_o ##1 !cfg_ack_o; endproperty
    a_ack: assert property (p_ack) else $error("ack not one cycle");
    property p_cause; cfg_ack_o |-> $past(tk); endproperty
    a_cause: assert property (p_cause) else $error("ack without request");
    property p_ptr;
        rd && cfg_dw_addr_i == 6'h0d |=> cfg_rdata_o[7:0] == 8'hdc;
    endproperty
    a_ptr: assert property (p_ptr) else $error("bad pointer");
    property p_hdr;
        rd && cfg_dw_addr_i == 6'h0f |=> cfg_rdata_o[31:8] == 24'h180801;
    endproperty
    a_hdr: assert property (p_hdr) else $error("bad header");
    property p_id; rpm |=> cfg_rdata_o[15:0] == 16'h0001; endproperty
    a_id: assert property (p_id) else $error("bad cap id");
    property p_fix;
        rpm |=> cfg_rdata_o[26:21] == 6'h31 && cfg_rdata_o[19:16] == 4'h2;
    endproperty
    a_fix: assert property (p_fix) else $error("bad caps");
    property p_wake;
        rpm |=> cfg_rdata_o[31:27] == (auxiliary_supply_i ? 5'h1f : 5'h03);
    endproperty
    a_wake: assert property (p_wake) else $error("bad wake");
    property p_mode; rpm |=> cfg_rdata_o[20] == cardbus_mode_i; endproperty
    a_mode: assert property (p_mode) else $error("bad mode bit");
    property p_hold; !rd |=> $stable(cfg_rdata_o); endproperty
    a_hold: assert property (p_hold) else $error("rdata moved");
    c_aux: cover property (rpm && auxiliary_supply_i);
    c_wr: cover property (tk && cfg_write_i && cfg_dw_addr_i == 6'h0f);
    c_pm: cover property (rpm && cardbus_mode_i);
endmodule // pcr_config_caps_props

bind pcr_config_caps pcr_config_caps_props u_props (.*);

// [verification/pcr_host_model.sv]
module pcr_host_model
(
    // bus side
    input  logic        clock_i,
    input  logic        ack_i,
    input  logic [31:0] rdata_i,
    output logic        req_o,
    output logic        write_o,
    output logic [5:0]  dw_addr_o,
    output logic [3:0]  byte_en_o,
    output logic [31:0] wdata_o
);
    timeunit 1ns;
    timeprecision 1ps;
    initial {req_o, write_o, dw_addr_o, byte_en_o, wdata_o} = '0;
    // held through the ack edge, then scrambled
    task access(input logic w, input logic [5:0] a, input logic [3:0] be,
                input logic [31:0] d, output logic [31:0] q);
        int n;
        q = 'x;
        n = 0;
        @(negedge clock_i);
        {req_o, write_o, dw_addr_o, byte_en_o, wdata_o} = {1'b1, w, a, be, d};
        do
        begin
            @(negedge clock_i);
            n++;
        end
        while (ack_i !== 1'b1 && n < 8);
        if (ack_i === 1'b1)
            q = rdata_i;
        @(negedge clock_i);
        {req_o, write_o, dw_addr_o, byte_en_o, wdata_o} = {1'b0, ~w, ~a, ~be, ~d};
    endtask
endmodule // pcr_host_model

// [verification/tb_pcr_config_caps.sv]
`define CHK(n,e,g) begin cmp_count++; if ((g) !== (e)) begin errors++; \
    $display("wrong value %s exp %h got %h", n, e, g); end end
module tb_pcr_config_caps;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clock_i = 0, rstn_i = 0, aux = 0, cb = 0;
    logic        req, wrt, ack;
    logic [5:0]  dwa;
    logic [3:0]  be;
    logic [31:0] wd, rdat, q;
    int          errors = 0, cmp_count = 0;
    always #2 clock_i = ~clock_i;
    pcr_config_caps u_dut (.clock_i(clock_i), .rstn_i(rstn_i),
        .cfg_req_i(req), .cfg_write_i(wrt), .cfg_dw_addr_i(dwa),
        .cfg_byte_en_i(be), .cfg_wdata_i(wd), .cfg_ack_o(ack),
        .cfg_rdata_o(rdat), .auxiliary_supply_i(aux), .cardbus_mode_i(cb));
    pcr_host_model u_host (.clock_i(clock_i), .ack_i(ack), .rdata_i(rdat),
        .req_o(req), .write_o(wrt), .dw_addr_o(dwa), .byte_en_o(be),
        .wdata_o(wd));
    ////////////////////////////////////////////////////////////////////////
    task rd(input logic [5:0] a); u_host.access(1'b0, a, 4'h0, 32'h0, q);
    endtask
    task wr(input logic [5:0] a, input logic [3:0] b, input logic [31:0] d);
        u_host.access(1'b1, a, b, d, q);
    endtask
    task t_header;
        rd(6'h0d); `CHK("cap ptr", 8'hdc, q[7:0])
        rd(6'h0f); `CHK("line", 8'h00, q[7:0])
        `CHK("pin grant lat", 24'h180801, q[31:8])
        rd(6'h37); `CHK("id next", 16'h0001, q[15:0])
        rd(6'h00); `CHK("unmapped", 32'h0, q)
    endtask
    task t_caps;
        logic [15:0] e;
        for (int i = 0; i < 4; i++)
        begin
            {aux, cb} = i[1:0];
            repeat (8) @(negedge clock_i);
            e = {i[1] ? 5'h1f : 5'h03, 5'b11000, 1'b1, i[0], 4'b0010};
            rd(6'h37); `CHK("caps", e, q[31:16])
        end
        wr(6'h37, 4'hf, 32'hffffffff);
        wr(6'h37, 4'hf, 32'h0);
        rd(6'h37); `CHK("caps wr", e, q[31:16])
    endtask
    task t_line;
        wr(6'h0f, 4'hf, 32'h5a5a5ac3);
        wr(6'h0f, 4'he, 32'h00000011);
        wr(6'h0d, 4'hf, 32'h0);
        rd(6'h0f); `CHK("line wr", 32'h180801c3, q)
        rd(6'h0d); `CHK("ptr wr", 8'hdc, q[7:0])
    endtask
    task t_reset;
        rstn_i = 0;
        repeat (3) @(negedge clock_i);
        rstn_i = 1;
        rd(6'h0f); `CHK("line rst", 8'h00, q[7:0])
    endtask
    task end_of_test;
        $display("checks %0d errors %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    initial
    begin
        #20000;
        errors++;
        end_of_test;
    end
    initial
    begin
        repeat (12) @(negedge clock_i);
        rstn_i = 1;
        repeat (6) @(negedge clock_i);
        t_header;
        t_caps;
        t_line;
        t_reset;
        end_of_test;
    end
endmodule // tb_pcr_config_caps

// [verilog/pcr_config_caps.v]
`include "pcr_consts.vh"

module pcr_config_caps
(
    // clock and reset
    input  wire        clock_i,
    input  wire        rstn_i,
    // configuration access port
    input  wire        cfg_req_i,
    input  wire        cfg_write_i,
    input  wire [5:0]  cfg_dw_addr_i,
    input  wire [3:0]  cfg_byte_en_i,
    input  wire [31:0] cfg_wdata_i,
    output wire        cfg_ack_o,
    output reg  [31:0] cfg_rdata_o,
    // board straps
    input  wire        auxiliary_supply_i,
    input  wire        cardbus_mode_i
);

    localparam ST_IDLE   = 1'b0;
    localparam ST_ANSWER = 1'b1;
    localparam PIN_CNT   = 2;

    ////////////////////////////////////////////////////////////////////////

    // does a dword index select the dword holding a byte offset
    function pcr_dw_hit;
        input [5:0] dw;
        input [7:0] ofs;
        begin
            pcr_dw_hit = (dw == ofs[7:2]);
        end
    endfunction

    // byte lane of a byte offset inside its dword
    function [1:0] pcr_lane;
        input [7:0] ofs;
        begin
            pcr_lane = ofs[1:0];
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // strap synchronisers: three stages, accept once stages 2 and 3 agree

    wire [PIN_CNT-1:0] pin_raw;
    reg  [PIN_CNT-1:0] pin_s1_r;
    reg  [PIN_CNT-1:0] pin_s2_r;
    reg  [PIN_CNT-1:0] pin_s3_r;
    reg  [PIN_CNT-1:0] pin_stable_r;

    assign pin_raw = {cardbus_mode_i, auxiliary_supply_i};

    genvar gi;
    generate
        for (gi = 0; gi < PIN_CNT; gi = gi + 1)
        begin : g_pin_sync
            always @(posedge clock_i or negedge rstn_i)
            begin
                if (!rstn_i)
                begin
                    pin_s1_r[gi]     <= 1'b0;
                    pin_s2_r[gi]     <= 1'b0;
                    pin_s3_r[gi]     <= 1'b0;
                    pin_stable_r[gi] <= 1'b0;
                end
                else
                begin
                    pin_s1_r[gi] <= pin_raw[gi];
                    pin_s2_r[gi] <= pin_s1_r[gi];
                    pin_s3_r[gi] <= pin_s2_r[gi];
                    if (pin_s2_r[gi] == pin_s3_r[gi])
                    begin
                        pin_stable_r[gi] <= pin_s3_r[gi];
                    end
                end
            end
        end
    endgenerate

    wire aux_present;
    wire cardbus_mode;

    assign aux_present  = pin_stable_r[0];
    assign cardbus_mode = pin_stable_r[1];

    ////////////////////////////////////////////////////////////////////////
    // power capabilities word, built from its fields

    reg [15:0] pmc_word;

    always @*
    begin
        pmc_word = 16'h0000;
        if (aux_present)
        begin
            pmc_word[`PCR_PMC_WAKE_MSB:`PCR_PMC_WAKE_LSB] =
                `PCR_PMC_WAKE_AUX;
        end
        else
        begin
            pmc_word[`PCR_PMC_WAKE_MSB:`PCR_PMC_WAKE_LSB] =
                `PCR_PMC_WAKE_NOAUX;
        end
        pmc_word[`PCR_PMC_D2_BIT] = `PCR_PMC_D2_VAL;
        pmc_word[`PCR_PMC_D1_BIT] = `PCR_PMC_D1_VAL;
        pmc_word[`PCR_PMC_AUXCUR_MSB:`PCR_PMC_AUXCUR_LSB] =
            `PCR_PMC_AUXCUR_VAL;
        pmc_word[`PCR_PMC_DSI_BIT] = `PCR_PMC_DSI_VAL;
        pmc_word[`PCR_PMC_AUXREQ_BIT] = cardbus_mode;
        pmc_word[`PCR_PMC_CLOCK_BIT] = `PCR_PMC_CLOCK_VAL;
        pmc_word[`PCR_PMC_VER_MSB:`PCR_PMC_VER_LSB] =
            `PCR_PMC_VER_VAL;
    end

    ////////////////////////////////////////////////////////////////////////
    // interrupt line byte, the only writable storage here

    reg  [7:0] irq_routing_line_r;
    reg  [7:0] irq_routing_line_nxt;
    reg        state_r;
    reg        state_nxt;
    wire       take;
    wire       line_hit;

    assign take     = (state_r == ST_IDLE) && cfg_req_i;
    assign line_hit = pcr_dw_hit(cfg_dw_addr_i, `PCR_OFS_IRQ_LINE);

    always @*
    begin
        irq_routing_line_nxt = irq_routing_line_r;
        // every other byte, pm word included, drops its write
        if (take && cfg_write_i && line_hit &&
            cfg_byte_en_i[pcr_lane(`PCR_OFS_IRQ_LINE)])
        begin
            irq_routing_line_nxt = cfg_wdata_i[7:0];
        end
    end

    always @(posedge clock_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            irq_routing_line_r <= `PCR_VAL_IRQ_LINE_RST;
        end
        else
        begin
            irq_routing_line_r <= irq_routing_line_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read data assembly per dword

    reg [31:0] read_word;

    always @*
    begin
        read_word = 32'h0000_0000;
        if (pcr_dw_hit(cfg_dw_addr_i, `PCR_OFS_CAP_PTR))
        begin
            read_word[7:0] = `PCR_VAL_CAP_PTR;
        end
        else if (line_hit)
        begin
            read_word[7:0]   = irq_routing_line_r;
            read_word[15:8]  = `PCR_VAL_IRQ_PIN_INTA;
            read_word[23:16] = `PCR_VAL_GRANT_MIN;
            read_word[31:24] = `PCR_VAL_LATENCY_MAX;
        end
        else if (pcr_dw_hit(cfg_dw_addr_i, `PCR_OFS_PM_CAP_ID))
        begin
            read_word[7:0]   = `PCR_VAL_PM_CAP_ID;
            read_word[15:8]  = `PCR_VAL_PM_NEXT;
            read_word[31:16] = pmc_word;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // access sequencer: take in idle, answer on the next cycle

    reg [31:0] rdata_nxt;

    always @*
    begin
        state_nxt = state_r;
        rdata_nxt = cfg_rdata_o;
        case (state_r)
            ST_IDLE:
            begin
                if (cfg_req_i)
                begin
                    state_nxt = ST_ANSWER;
                    if (!cfg_write_i)
                    begin
                        rdata_nxt = read_word;
                    end
                end
            end
            ST_ANSWER:
            begin
                state_nxt = ST_IDLE;
            end
            default:
            begin
                state_nxt = ST_IDLE;
            end
        endcase
    end

    always @(posedge clock_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            state_r     <= ST_IDLE;
            cfg_rdata_o <= 32'h0000_0000;
        end
        else
        begin
            state_r     <= state_nxt;
            cfg_rdata_o <= rdata_nxt;
        end
    end

    assign cfg_ack_o = (state_r == ST_ANSWER);

endmodule // pcr_config_caps

// [verilog/pcr_consts.vh]
`ifndef PCR_CONSTS_VH
`define PCR_CONSTS_VH

// configuration byte offsets
`define PCR_OFS_CAP_PTR      8'h34
`define PCR_OFS_IRQ_LINE     8'h3c
`define PCR_OFS_IRQ_PIN      8'h3d
`define PCR_OFS_GRANT_MIN    8'h3e
`define PCR_OFS_LATENCY_MAX  8'h3f
`define PCR_OFS_PM_CAP_ID    8'hdc
`define PCR_OFS_PM_NEXT      8'hdd
`define PCR_OFS_PM_CAPS      8'hde

// fixed and reset values
`define PCR_VAL_CAP_PTR      8'hdc
`define PCR_VAL_IRQ_LINE_RST 8'h00
`define PCR_VAL_IRQ_PIN_INTA 8'h01
`define PCR_VAL_GRANT_MIN    8'h08
`define PCR_VAL_LATENCY_MAX  8'h18
`define PCR_VAL_PM_CAP_ID    8'h01
`define PCR_VAL_PM_NEXT      8'h00

// power capabilities word fields
`define PCR_PMC_WAKE_MSB     15
`define PCR_PMC_WAKE_LSB     11
`define PCR_PMC_D2_BIT       10
`define PCR_PMC_D1_BIT       9
`define PCR_PMC_AUXCUR_MSB   8
`define PCR_PMC_AUXCUR_LSB   6
`define PCR_PMC_DSI_BIT      5
`define PCR_PMC_AUXREQ_BIT   4
`define PCR_PMC_CLOCK_BIT    3
`define PCR_PMC_VER_MSB      2
`define PCR_PMC_VER_LSB      0
`define PCR_PMC_WAKE_AUX     5'h1f
`define PCR_PMC_WAKE_NOAUX   5'h03
`define PCR_PMC_D2_VAL       1'h1
`define PCR_PMC_D1_VAL       1'h1
`define PCR_PMC_AUXCUR_VAL   3'h0
`define PCR_PMC_DSI_VAL      1'h1
`define PCR_PMC_CLOCK_VAL    1'h0
`define PCR_PMC_VER_VAL      3'h2

`endif
